// ==== logic/watch_timer_pkg.sv ====
// Package with register map, field layout and bus carrier for the watch timer.
//
// Overview of operation
// RQ1 - Prescaler mode register: 8 bits, resets 00H.
// RQ2 - Software configures prescaler mode before enabling.
// RQ3 - Software programs registers for 32.768 kHz.
// RQ4 - Compare register: 8 bits, byte access, 00H.
// RQ5 - Derived clock is source over 2N, 00H=256.
// RQ6 - Software sets prescaler before the mode register.
// RQ7 - Mode register: 8 bits, bits 1:0 controls.
// RQ8 - Mode register resets 00H, counter stopped.
// RQ9 - Bits 7:4 pick interval; bit 7 picks source.
// RQ10 - Bits 3:2 pick watch-flag period.
// RQ11 - Bit 1 starts 5-bit counter, else cleared.
// RQ12 - Bit 0 enables; clear stops and clears both.
// RQ13 - Software changes bits 7:2 only when stopped.
// RQ14 - Interval request each time the interval elapses.
// RQ15 - Watch request each time the flag period elapses.
// RQ16 - Requests are single-cycle pulses on the tap transition.
package watch_timer_pkg;

    // Word indices; the byte address is four times the index.
    localparam logic [29:0] IDX_PRESCALER_MODE = 30'h0ffff8b0;
    localparam logic [29:0] IDX_PRESCALER_COMPARE = 30'h0ffff8b1;
    localparam logic [29:0] IDX_WATCH_MODE = 30'h0ffff8b2;
    localparam logic [29:0] IDX_IRQ_STATUS = 30'h0ffff8b4;
    localparam logic [29:0] IDX_IRQ_MASK = 30'h0ffff8b5;

    // Reset values of all registers.
    localparam logic [7:0] RST_PRESCALER_MODE = 8'h00;
    localparam logic [7:0] RST_PRESCALER_COMPARE = 8'h00;
    localparam logic [7:0] RST_WATCH_MODE = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

    // Prescaler mode register fields.
    localparam int POS_DERIVED_CLOCK_ENABLE = 7;
    localparam int POS_SRC_DIV_LO = 0;

    // Watch mode register fields.
    localparam int POS_WATCH_RUN_ENABLE = 0;
    localparam int POS_COUNTER5_START = 1;
    localparam int POS_FLAG_PERIOD_SEL_LO = 2;
    localparam int POS_FLAG_PERIOD_SEL_HI = 3;
    localparam int POS_INTERVAL_SEL_0 = 4;
    localparam int POS_SOURCE_AND_INTERVAL_SEL = 7;

    // Interrupt status and mask fields.
    localparam int POS_IRQ_WATCH = 0;
    localparam int POS_IRQ_INTERVAL = 1;

    // Smallest interval tap exponent of the 11-bit prescaler.
    localparam int INTERVAL_TAP_BASE = 4;

    // One Wishbone request as seen by the slave.
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [31:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_s;

endpackage

// ==== logic/watch_timer.sv ====
// Watch timer and interval timer with a classic Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
module watch_timer
    import watch_timer_pkg::*;
(
    // Clock and synchronous reset.
    input wire logic CLK,
    input wire logic SRST,
    // Wishbone slave.
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [31:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Subclock pin from outside.
    input wire logic SUBCLK_IN,
    // Interrupt outputs.
    output logic IRQ,
    output logic WATCH_IRQ,
    output logic INTERVAL_IRQ
);

    // Bundled bus request.
    wb_req_s req;
    // Registers seen by software.
    logic [7:0] prescaler_mode_reg_q;
    logic [7:0] prescaler_compare_q;
    logic [7:0] watch_mode_control_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    // Write strobe for the low byte lane.
    logic wr_lo;
    // Subclock synchroniser and filtered level.
    logic sub_s1_q, sub_s2_q, sub_s3_q, sub_lvl_q;
    logic sub_tick;
    // Derived clock generator state.
    logic [2:0] pre3_q;
    logic [2:0] div_mask;
    logic src_tick;
    logic [7:0] cnt8_q;
    logic [7:0] n_minus1;
    logic half_q;
    logic brg_tick_q;
    // Watch clock tick and counters.
    logic fw_tick;
    logic [10:0] presc_q;
    logic [10:0] int_mask;
    logic int_hit;
    logic c5_tick;
    logic [4:0] cnt5_q;
    logic watch_hit;

    // Gather the bus ports into one request.
    assign req = '{cyc: CYC_I, stb: STB_I, we: WE_I, adr: ADR_I,
                   sel: SEL_I, dat: DAT_I};

    // A write lands on the edge at which the master samples ack high,
    // so the register changes exactly when the transfer completes.
    assign wr_lo = req.cyc && req.stb && req.we && ACK_O && req.sel[0];

    // Ack answers one cycle after the request and drops the next cycle.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= req.cyc && req.stb && !ACK_O;
        end
    end

    // Read data is registered; unmapped words read as zero.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DAT_O <= 32'h0;
        end else if (req.cyc && req.stb && !req.we && !ACK_O) begin
            case (req.adr[31:2])
                IDX_PRESCALER_MODE: DAT_O <= {24'h0, prescaler_mode_reg_q};
                IDX_PRESCALER_COMPARE: DAT_O <= {24'h0, prescaler_compare_q};
                IDX_WATCH_MODE: DAT_O <= {24'h0, watch_mode_control_q};
                IDX_IRQ_STATUS: DAT_O <= {30'h0, irq_status_q};
                IDX_IRQ_MASK: DAT_O <= {30'h0, irq_mask_q};
                default: DAT_O <= 32'h0;
            endcase
        end
    end

    // Prescaler mode register, byte written through lane 0.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            prescaler_mode_reg_q <= RST_PRESCALER_MODE; // RQ1
        end else if (wr_lo && req.adr[31:2] == IDX_PRESCALER_MODE) begin
            prescaler_mode_reg_q <= req.dat[7:0]; // RQ1
        end
    end

    // Compare register, written only as a whole byte.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            prescaler_compare_q <= RST_PRESCALER_COMPARE; // RQ4
        end else if (wr_lo && req.adr[31:2] == IDX_PRESCALER_COMPARE) begin
            prescaler_compare_q <= req.dat[7:0]; // RQ4
        end
    end

    // Watch mode register; a bit write is a read-modify-write byte.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            watch_mode_control_q <= RST_WATCH_MODE; // RQ8
        end else if (wr_lo && req.adr[31:2] == IDX_WATCH_MODE) begin
            watch_mode_control_q <= req.dat[7:0]; // RQ7
        end
    end

    // Interrupt mask register.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_mask_q <= RST_IRQ;
        end else if (wr_lo && req.adr[31:2] == IDX_IRQ_MASK) begin
            irq_mask_q <= req.dat[1:0];
        end
    end

    // Sticky status; writing one clears, a new event wins over the clear.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_status_q <= RST_IRQ;
        end else begin
            irq_status_q[POS_IRQ_WATCH] <= watch_hit ||
                (irq_status_q[POS_IRQ_WATCH] &&
                 !(wr_lo && req.adr[31:2] == IDX_IRQ_STATUS &&
                   req.dat[POS_IRQ_WATCH]));
            irq_status_q[POS_IRQ_INTERVAL] <= int_hit ||
                (irq_status_q[POS_IRQ_INTERVAL] &&
                 !(wr_lo && req.adr[31:2] == IDX_IRQ_STATUS &&
                   req.dat[POS_IRQ_INTERVAL]));
        end
    end

    // Level interrupt, high while an unmasked status bit is set.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status_q & irq_mask_q);
        end
    end

    // Three-stage synchroniser for the subclock pin.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
            sub_lvl_q <= 1'b0;
        end else begin
            sub_s1_q <= SUBCLK_IN;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
            // The level only moves once two stages agree.
            if (sub_s2_q == sub_s3_q) begin
                sub_lvl_q <= sub_s3_q;
            end
        end
    end

    // One tick on each accepted rising edge of the subclock.
    assign sub_tick = (sub_s2_q == sub_s3_q) && sub_s3_q && !sub_lvl_q;

    // Source clock is the main clock divided by two to the power m.
    assign div_mask = 3'((4'h1 << prescaler_mode_reg_q[POS_SRC_DIV_LO +: 2])
                         - 4'h1);
    assign src_tick = (pre3_q & div_mask) == div_mask;
    // Stored zero wraps to 255, so the count spans 256 ticks.
    assign n_minus1 = prescaler_compare_q - 8'h01; // RQ5

    // 3-bit prescaler runs only while the derived clock is enabled.
    always_ff @(posedge CLK) begin
        if (SRST || !prescaler_mode_reg_q[POS_DERIVED_CLOCK_ENABLE]) begin
            pre3_q <= 3'h0;
        end else begin
            pre3_q <= pre3_q + 3'h1;
        end
    end

    // 8-bit counter toggles a half period every N source ticks.
    always_ff @(posedge CLK) begin
        if (SRST || !prescaler_mode_reg_q[POS_DERIVED_CLOCK_ENABLE]) begin
            cnt8_q <= 8'h00;
            half_q <= 1'b0;
            brg_tick_q <= 1'b0;
        end else begin
            brg_tick_q <= 1'b0;
            if (src_tick) begin
                if (cnt8_q == n_minus1) begin
                    cnt8_q <= 8'h00;
                    half_q <= !half_q; // RQ5
                    // One derived-clock period per full cycle of half.
                    brg_tick_q <= !half_q; // RQ5
                end else begin
                    cnt8_q <= cnt8_q + 8'h01;
                end
            end
        end
    end

    // Watch clock is the subclock or the derived clock by bit 7.
    assign fw_tick = watch_mode_control_q[POS_SOURCE_AND_INTERVAL_SEL] ?
                     brg_tick_q : sub_tick; // RQ9

    // 11-bit prescaler counts while enabled, cleared when stopped.
    always_ff @(posedge CLK) begin
        if (SRST || !watch_mode_control_q[POS_WATCH_RUN_ENABLE]) begin
            presc_q <= 11'h000; // RQ12
        end else if (fw_tick) begin
            presc_q <= presc_q + 11'h001;
        end
    end

    // Interval period is two to the power (4 + bits 6:4).
    assign int_mask = 11'((12'h001 << (INTERVAL_TAP_BASE +
        int'(watch_mode_control_q[POS_INTERVAL_SEL_0 +: 3]))) - 12'h001);
    assign int_hit = fw_tick && watch_mode_control_q[POS_WATCH_RUN_ENABLE] &&
                     ((presc_q & int_mask) == int_mask); // RQ14

    // 5-bit counter counts fw, or fw/512 for the long periods.
    assign c5_tick = fw_tick && watch_mode_control_q[POS_WATCH_RUN_ENABLE] &&
                     (watch_mode_control_q[POS_FLAG_PERIOD_SEL_HI] ||
                      presc_q[8:0] == 9'h1ff); // RQ10
    assign watch_hit = c5_tick && watch_mode_control_q[POS_COUNTER5_START] &&
        (watch_mode_control_q[POS_FLAG_PERIOD_SEL_LO] ?
         cnt5_q[3:0] == 4'hf : cnt5_q == 5'h1f); // RQ15

    // 5-bit counter runs with bits 1:0 set, cleared otherwise.
    always_ff @(posedge CLK) begin
        if (SRST || !watch_mode_control_q[POS_WATCH_RUN_ENABLE] ||
            !watch_mode_control_q[POS_COUNTER5_START]) begin
            cnt5_q <= 5'h00; // RQ11
        end else if (c5_tick) begin
            cnt5_q <= cnt5_q + 5'h01;
        end
    end

    // Single-cycle request pulses, registered for clean outputs.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            WATCH_IRQ <= 1'b0;
            INTERVAL_IRQ <= 1'b0;
        end else begin
            WATCH_IRQ <= watch_hit; // RQ16
            INTERVAL_IRQ <= int_hit; // RQ16
        end
    end

    // Helper: cycles between derived ticks under a steady setup.
    logic [12:0] gap_q;
    logic gap_ok_q;
    logic [12:0] brg_period;
    assign brg_period = 13'((prescaler_compare_q == 8'h00 ? 13'h100 :
        {5'h0, prescaler_compare_q}) <<
        ({1'b0, prescaler_mode_reg_q[POS_SRC_DIV_LO +: 2]} + 3'h1));
    always_ff @(posedge CLK) begin
        if (SRST || wr_lo ||
            !prescaler_mode_reg_q[POS_DERIVED_CLOCK_ENABLE]) begin
            gap_q <= 13'h0;
            gap_ok_q <= 1'b0;
        end else if (brg_tick_q) begin
            gap_q <= 13'h1;
            gap_ok_q <= 1'b1;
        end else if (gap_q != 13'h1fff) begin
            gap_q <= gap_q + 13'h1;
        end
    end

    // Mode register comes out of reset cleared.
    mode_reset_a: assert property (@(posedge CLK) // RQ8
        $past(SRST) |-> watch_mode_control_q == 8'h00 && cnt5_q == 5'h00)
        else $error("watch mode register not cleared by reset");

    // Prescaler mode register comes out of reset cleared.
    pmode_reset_a: assert property (@(posedge CLK) // RQ1
        $past(SRST) |-> prescaler_mode_reg_q == 8'h00)
        else $error("prescaler mode register not cleared by reset");

    // Compare register comes out of reset cleared.
    compare_reset_a: assert property (@(posedge CLK) // RQ4
        $past(SRST) |-> prescaler_compare_q == 8'h00)
        else $error("compare register not cleared by reset");

    // Derived ticks are spaced by 2N source periods.
    brg_period_a: assert property (@(posedge CLK) disable iff (SRST) // RQ5
        brg_tick_q && gap_ok_q && !$past(wr_lo) |-> gap_q == brg_period)
        else $error("derived clock period wrong");

    // Stopping clears the prescaler on the next edge.
    presc_stop_a: assert property (@(posedge CLK) disable iff (SRST) // RQ12
        !watch_mode_control_q[POS_WATCH_RUN_ENABLE] |=>
        (presc_q == 11'h000 && !INTERVAL_IRQ) ##1 !INTERVAL_IRQ)
        else $error("prescaler not cleared while stopped");

    // Without the start bit the 5-bit counter holds zero.
    cnt5_clear_a: assert property (@(posedge CLK) disable iff (SRST) // RQ11
        !watch_mode_control_q[POS_COUNTER5_START] |=> cnt5_q == 5'h00)
        else $error("5-bit counter not cleared");

    // Interval request lands on a tap boundary.
    interval_tap_a: assert property (@(posedge CLK) disable iff (SRST) // RQ14
        int_hit |=> (presc_q & $past(int_mask)) == 11'h000 && INTERVAL_IRQ)
        else $error("interval request off the selected tap");

    // Watch request lands when the low four bits of the 5-bit count wrap.
    watch_wrap_a: assert property (@(posedge CLK) disable iff (SRST) // RQ15
        watch_hit |=> WATCH_IRQ && (cnt5_q[3:0] == 4'h0))
        else $error("watch request not on counter wrap");

    // Request pulses last exactly one cycle.
    irq_pulse_a: assert property (@(posedge CLK) disable iff (SRST) // RQ16
        (WATCH_IRQ || INTERVAL_IRQ) |=> !WATCH_IRQ && !INTERVAL_IRQ)
        else $error("request pulse malformed");

    // Bus ack is a single-cycle pulse.
    ack_pulse_a: assert property (@(posedge CLK) disable iff (SRST)
        ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ==== tb/watch_timer_tb.sv ====
// Self-checking bench for the watch timer and its register slave.
`timescale 1ns/1ps
`default_nettype none
module watch_timer_tb import watch_timer_pkg::*;;
    // Unmapped word index between the mode register and the status.
    localparam logic [29:0] IDX_FREE = 30'h0ffff8b3;
    // Bench-side copies of the design's ports.
    logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = '0, wdat = '0, rdat;
    logic [3:0] sel = '0;
    logic ack, irq, wirq, iirq;
    logic sub = 1'b0, sub_on = 1'b0;
    int sub_cnt = 0, cycles = 0, n_fail = 0, check_count = 0;
    logic [31:0] q;
    // Last mode value that the configuration task wrote.
    logic [7:0] mode_now = 8'h00;

    watch_timer dut_u (.CLK(clk), .SRST(srst), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
        .ACK_O(ack), .SUBCLK_IN(sub), .IRQ(irq), .WATCH_IRQ(wirq),
        .INTERVAL_IRQ(iirq));

    // Clock of 5 ns period.
    always #2.5 clk = ~clk;

    // Subclock: four cycles high, four low, only while enabled.
    always @(posedge clk) begin
        if (sub_on) begin
            sub_cnt <= (sub_cnt == 3) ? 0 : sub_cnt + 1;
            if (sub_cnt == 3) begin
                sub <= ~sub;
            end
        end
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic print_verdict();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short after a ceiling well above the expected run.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            n_fail++;
            print_verdict();
        end
    end

    // Compares one value and counts any mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; holds the request until ack is seen.
    task automatic wb(input logic w, input logic [29:0] idx,
                      input logic [7:0] d, input logic s0);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= {3'b000, s0};
        wdat <= {24'h0, d};
        // Ack and read data are both taken at the same rising edge.
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1) begin
            check(32'h0, 32'h1);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [29:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 1'b1);
    endtask
    task automatic rd(input logic [29:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00, 1'b0);
        check(q, {24'h0, e});
    endtask

    // Measures the spacing of two pulses; a wide pulse gives a gap of 1.
    task automatic gap(input logic w, input int exp);
        int n, k;
        n = 0;
        k = 0;
        while (k < 2 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
            if ((w ? iirq : wirq) === 1'b1) begin
                if (k == 1) begin
                    check(n, exp);
                end
                k++;
                n = 0;
            end
        end
        if (k < 2) begin
            check(32'h0, exp);
        end
    endtask

    // Counts pulses over a window in which none may appear.
    task automatic quiet(input logic w, input int len);
        int c;
        c = 0;
        repeat (len) begin
            @(posedge clk);
            #1;
            if ((w ? iirq : wirq) !== 1'b0) begin
                c++;
            end
        end
        check(c, 0);
    endtask

    // Stops, programs the divider in order, then starts the timer.
    task automatic cfg(input logic [7:0] pm, cm, md);
        wr(IDX_WATCH_MODE, mode_now & 8'hfc);
        wr(IDX_WATCH_MODE, 8'h00);
        wr(IDX_PRESCALER_MODE, pm & 8'h7f);
        wr(IDX_PRESCALER_COMPARE, cm);
        wr(IDX_PRESCALER_MODE, pm);
        wr(IDX_WATCH_MODE, md & 8'hfc);
        wr(IDX_WATCH_MODE, md);
        mode_now = md;
    endtask

    // Reset values of every register and quiet outputs.
    task automatic t_reset();
        rd(IDX_PRESCALER_MODE, 8'h00);
        rd(IDX_PRESCALER_COMPARE, 8'h00);
        rd(IDX_WATCH_MODE, 8'h00);
        rd(IDX_IRQ_STATUS, 8'h00);
        rd(IDX_IRQ_MASK, 8'h00);
        quiet(1'b0, 50);
        quiet(1'b1, 50);
        check(irq, 1'b0);
    endtask

    // Write and read back; a disabled byte lane and a free index.
    task automatic t_regs();
        wr(IDX_PRESCALER_MODE, 8'h03);
        wr(IDX_PRESCALER_MODE, 8'h83);
        rd(IDX_PRESCALER_MODE, 8'h83);
        wr(IDX_PRESCALER_COMPARE, 8'ha5);
        wb(1'b1, IDX_PRESCALER_COMPARE, 8'h5a, 1'b0);
        rd(IDX_PRESCALER_COMPARE, 8'ha5);
        wr(IDX_WATCH_MODE, 8'hfc);
        rd(IDX_WATCH_MODE, 8'hfc);
        wr(IDX_FREE, 8'h55);
        rd(IDX_FREE, 8'h00);
        wr(IDX_WATCH_MODE, 8'h00);
        wr(IDX_PRESCALER_MODE, 8'h00);
        wr(IDX_PRESCALER_COMPARE, 8'h00);
    endtask

    // Periods from the derived clock: all interval codes, divider cases.
    task automatic t_rates();
        for (int k = 0; k < 8; k++) begin
            cfg(8'h80, 8'h01, 8'h83 | 8'(k << 4));
            gap(1'b1, 32 << k);
        end
        cfg(8'h80, 8'h01, 8'h8f);
        gap(1'b0, 32);
        cfg(8'h80, 8'h02, 8'h9b);
        gap(1'b0, 128);
        gap(1'b1, 128);
        cfg(8'h81, 8'h01, 8'h83);
        gap(1'b1, 64);
        cfg(8'h80, 8'h00, 8'h83);
        gap(1'b1, 8192);
        cfg(8'h83, 8'h01, 8'h83);
        gap(1'b1, 256);
        cfg(8'h80, 8'h01, 8'h87);
        gap(1'b0, 16384);
    endtask

    // Subclock as watch clock when the source bit is zero.
    task automatic t_sub();
        sub_on <= 1'b1;
        cfg(8'h80, 8'h01, 8'h0f);
        gap(1'b1, 128);
        gap(1'b0, 128);
        sub_on <= 1'b0;
    endtask

    // Sticky status, mask and the level interrupt.
    task automatic t_irq();
        cfg(8'h80, 8'h01, 8'h8f);
        wr(IDX_IRQ_MASK, 8'h00);
        repeat (80) @(posedge clk);
        #1;
        check(irq, 1'b0);
        rd(IDX_IRQ_STATUS, 8'h03);
        wr(IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check(irq, 1'b1);
        wr(IDX_WATCH_MODE, 8'h8c);
        repeat (4) @(posedge clk);
        wr(IDX_IRQ_STATUS, 8'h01);
        rd(IDX_IRQ_STATUS, 8'h02);
        check(irq, 1'b0);
        wr(IDX_IRQ_MASK, 8'h03);
        repeat (2) @(posedge clk);
        #1;
        check(irq, 1'b1);
        wr(IDX_IRQ_STATUS, 8'h02);
        rd(IDX_IRQ_STATUS, 8'h00);
        check(irq, 1'b0);
        rd(IDX_IRQ_MASK, 8'h03);
    endtask

    // Counter start bit and run bit stop the matching pulses.
    task automatic t_stop();
        cfg(8'h80, 8'h01, 8'h8f);
        wr(IDX_WATCH_MODE, 8'h8d);
        gap(1'b1, 32);
        quiet(1'b0, 200);
        wr(IDX_WATCH_MODE, 8'h8c);
        repeat (4) @(posedge clk);
        quiet(1'b1, 200);
        quiet(1'b0, 200);
    endtask

    // Main sequence: reset for six cycles, then every scenario.
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_regs();
        t_rates();
        t_sub();
        t_irq();
        t_stop();
        print_verdict();
    end
endmodule
`default_nettype wire
